// *** rtl/dcb_button_pick.sv ***
// picks one function button state by its stored button number
`timescale 1ns/1ps
`default_nettype none
`include "dcb_defs.svh"

module dcb_button_pick (
   input  wire logic [31:0] buttons,
   input  wire logic [7:0]  sel,
   output logic             pressed
);
   // field is six bits wide; numbers outside 1..29 select nothing
   always_comb begin
      if ((sel[5:0] != 6'h00) && (sel[5:0] <= 6'(`DCB_BTN_MAX))) begin
         pressed = buttons[sel[4:0]];
      end else begin
         pressed = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** rtl/dcb_cv_bank.sv ***
// configuration-variable bank and feature control of the sound decoder
`timescale 1ns/1ps
`default_nettype none
`include "dcb_defs.svh"

module dcb_cv_bank
   import dcb_pkg::*;
#(
   parameter int         RAMP_STEP_CYCLES = `DCB_RAMP_STEP_NS / `DCB_CLK_PERIOD_NS,
   parameter int         RAMP_STEP        = 1,
   parameter int         CONSIST_BUTTON   = 7,
   parameter logic [7:0] MAKER_ID         = 8'h5A // arbitrary value
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        NV_INIT_N,
   input  wire logic        CV_WR_EN,
   input  wire logic        CV_RD_EN,
   input  wire logic [9:0]  CV_NUM,
   input  wire logic [7:0]  CV_WDATA,
   output logic      [7:0]  CV_RDATA,
   output logic             CV_RD_VALID,
   input  wire logic [31:0] FUNC_BUTTONS,
   input  wire logic [7:0]  THROTTLE,
   input  wire logic        ACCELERATING,
   input  wire logic        DECELERATING,
   input  wire logic        STOPPED,
   input  wire logic [3:0]  TRACK_OUTPUT_FLAG,
   input  wire logic        EXT_TRIGGER,
   input  wire logic        PUFF_TIMER_TICK,
   input  wire logic        CONSIST_CONFIGURED,
   output logic      [7:0]  FADE_GAIN,
   output logic      [7:0]  MASTER_GAIN,
   output logic             NEUTRAL_ACTIVE,
   output logic      [7:0]  MOTOR_SPEED_CMD,
   output logic      [7:0]  ENGINE_SOUND_LEVEL,
   output logic             ACCEL_INHIBIT,
   output logic      [7:0]  ACK_STRENGTH,
   output logic             DIR_REVERSE,
   output logic             ANALOG_EN,
   output logic             TELEMETRY_EN,
   output logic             SPEED_TABLE_28,
   output logic             LONG_ADDR_EN,
   output logic      [13:0] LONG_ADDRESS,
   output logic             LOAD_CTRL_EN,
   output logic             CONST_BRAKE_EN,
   output logic             RAMP_PROLONG,
   output logic             FUNC_SAVE_EN,
   output logic      [15:0] FUNC_SAVED,
   output logic             CONSIST_ACTIVE,
   output logic             PUFF_START,
   output logic             ENERGY_PACK_EN,
   output logic             SUSI_EN,
   output logic             MAIN_SOUND_ON,
   output logic             SHUNT_MODE,
   output logic      [6:0]  AUX_OUT
);
   import dcb_pkg::*;

   // ==================================================================
   // factory image
   localparam dcb_cv_type CV_DEFAULT = '{
      primary:      `DCB_RST_PRIMARY,
      secondary:    `DCB_RST_SECONDARY,
      neutral_sel:  `DCB_RST_NEUTRAL_SEL,
      mute_sel:     `DCB_RST_MUTE_SEL,
      idle_fade:    `DCB_RST_IDLE_FADE,
      accel_sel:    `DCB_RST_ACCEL_SEL,
      ack_strength: `DCB_RST_ACK_STRENGTH,
      long_high:    `DCB_RST_LONG_HIGH,
      long_low:     `DCB_RST_LONG_LOW
   };

   localparam logic [15:0] TICK_LAST = 16'(RAMP_STEP_CYCLES - 1);

   dcb_state_type s_q;
   dcb_state_type s_d;
   logic          ramp_tick;
   logic          neutral_btn;
   logic          mute_btn;
   logic [7:0]    fade_target;
   logic [7:0]    mute_target;
   logic [7:0]    read_mux;
   logic [7:0]    high_part;

   // ==================================================================
   // button selection
   dcb_button_pick u_neutral_pick (
      .buttons (FUNC_BUTTONS),
      .sel     (s_q.cv.neutral_sel),
      .pressed (neutral_btn)
   );

   dcb_button_pick u_mute_pick (
      .buttons (FUNC_BUTTONS),
      .sel     (s_q.cv.mute_sel),
      .pressed (mute_btn)
   );

   // ==================================================================
   // gain ramps
   assign ramp_tick   = (s_q.tick_cnt == TICK_LAST);
   assign fade_target = (ACCELERATING || DECELERATING) ? 8'hFF : s_q.cv.idle_fade;
   assign mute_target = mute_btn ? 8'h00 : 8'hFF;

   dcb_gain_ramp #(
      .WIDTH (8),
      .STEP  (RAMP_STEP)
   ) u_fade_ramp (
      .clk     (REF_CLK),
      .rst_n   (RST_N),
      .step_en (ramp_tick),
      .target  (fade_target),
      .gain    (FADE_GAIN)
   );

   dcb_gain_ramp #(
      .WIDTH (8),
      .STEP  (RAMP_STEP)
   ) u_mute_ramp (
      .clk     (REF_CLK),
      .rst_n   (RST_N),
      .step_en (ramp_tick),
      .target  (mute_target),
      .gain    (MASTER_GAIN)
   );

   // ==================================================================
   // read mux; unmapped numbers read zero
   always_comb begin
      unique case (CV_NUM)
         `DCB_CV_COMMAND:      read_mux = MAKER_ID;
         `DCB_CV_LONG_HIGH:    read_mux = s_q.cv.long_high;
         `DCB_CV_LONG_LOW:     read_mux = s_q.cv.long_low;
         `DCB_CV_PRIMARY:      read_mux = s_q.cv.primary;
         `DCB_CV_SECONDARY:    read_mux = s_q.cv.secondary;
         `DCB_CV_ACK_STRENGTH: read_mux = s_q.cv.ack_strength;
         `DCB_CV_NEUTRAL_SEL:  read_mux = s_q.cv.neutral_sel;
         `DCB_CV_MUTE_SEL:     read_mux = s_q.cv.mute_sel;
         `DCB_CV_IDLE_FADE:    read_mux = s_q.cv.idle_fade;
         `DCB_CV_ACCEL_SEL:    read_mux = s_q.cv.accel_sel;
         default:              read_mux = 8'h00;
      endcase
   end

   // ==================================================================
   // next state
   always_comb begin
      s_d        = s_q;
      s_d.rvalid = CV_RD_EN;
      s_d.rdata  = CV_RD_EN ? read_mux : s_q.rdata;
      s_d.tick_cnt = ramp_tick ? 16'h0000 : s_q.tick_cnt + 16'h0001;

      // writes while restarting are lost, so a save cannot slip into the image
      if (CV_WR_EN && RST_N) begin
         unique case (CV_NUM)
            `DCB_CV_COMMAND: begin
               // restore and reload only arm; the image changes at the next restart
               if (CV_WDATA == `DCB_CMD_RESTORE) begin
                  s_d.pend = PEND_RESTORE;
               end else if (CV_WDATA == `DCB_CMD_RELOAD) begin
                  s_d.pend = PEND_RELOAD;
               end else if (CV_WDATA == `DCB_CMD_SAVE) begin
                  s_d.shadow = s_q.cv;
               end
            end
            `DCB_CV_LONG_HIGH:    s_d.cv.long_high    = CV_WDATA;
            `DCB_CV_LONG_LOW:     s_d.cv.long_low     = CV_WDATA;
            `DCB_CV_PRIMARY:      s_d.cv.primary      = CV_WDATA;
            `DCB_CV_SECONDARY:    s_d.cv.secondary    = CV_WDATA;
            `DCB_CV_ACK_STRENGTH: s_d.cv.ack_strength = CV_WDATA;
            `DCB_CV_NEUTRAL_SEL:  s_d.cv.neutral_sel  = CV_WDATA;
            `DCB_CV_MUTE_SEL:     s_d.cv.mute_sel     = CV_WDATA;
            `DCB_CV_IDLE_FADE:    s_d.cv.idle_fade    = CV_WDATA;
            `DCB_CV_ACCEL_SEL:    s_d.cv.accel_sel    = CV_WDATA;
            default: begin
            end
         endcase
      end

      // neutral gear: armed by its button, only from a stopping loco
      unique case (s_q.ng)
         NG_OFF: begin
            if (neutral_btn && (STOPPED || DECELERATING)) begin
               s_d.ng = NG_RUN;
            end
         end
         NG_RUN: begin
            if (!neutral_btn && (THROTTLE == 8'h00)) begin
               s_d.ng = NG_OFF;
            end
         end
      endcase

      if (s_d.ng == NG_RUN) begin
         s_d.motor_cmd    = 8'h00;
         s_d.engine_level = THROTTLE;
      end else begin
         s_d.motor_cmd    = THROTTLE;
         s_d.engine_level = 8'h00;
      end

      s_d.inhibit = |(TRACK_OUTPUT_FLAG & s_q.cv.accel_sel[3:0]);

      s_d.trig_q = EXT_TRIGGER;
      if (s_q.cv.secondary[`DCB_SEC_EXT_TRIGGER]) begin
         s_d.puff = EXT_TRIGGER && !s_q.trig_q;
      end else begin
         s_d.puff = PUFF_TIMER_TICK;
      end

      if (s_q.cv.secondary[`DCB_SEC_FUNC_SAVE]) begin
         s_d.saved_func = FUNC_BUTTONS[`DCB_BTN_SAVE_FIRST +: 16];
      end

      // restart: the armed command decides which image comes back
      if (!RST_N) begin
         // an nv clear in the same cycle forces the factory image, so one edge suffices
         s_d.cv           = ((s_q.pend == PEND_RELOAD) && NV_INIT_N) ? s_q.shadow
                                                                      : CV_DEFAULT;
         s_d.pend         = PEND_NONE;
         s_d.ng           = NG_OFF;
         s_d.tick_cnt     = 16'h0000;
         s_d.trig_q       = 1'b0;
         s_d.puff         = 1'b0;
         s_d.inhibit      = 1'b0;
         s_d.motor_cmd    = 8'h00;
         s_d.engine_level = 8'h00;
         s_d.rdata        = 8'h00;
         s_d.rvalid       = 1'b0;
      end
      // shadow and saved buttons survive RST_N and are cleared only here; pend is also cleared by RST_N
      if (!NV_INIT_N) begin
         s_d.shadow     = CV_DEFAULT;
         s_d.pend       = PEND_NONE;
         s_d.saved_func = 16'h0000;
      end
   end

   always_ff @(posedge REF_CLK) begin
      s_q <= s_d;
   end

   // ==================================================================
   // outputs
   assign high_part = s_q.cv.long_high - `DCB_LONG_HIGH_BASE;

   assign CV_RDATA           = s_q.rdata;
   assign CV_RD_VALID        = s_q.rvalid;
   assign NEUTRAL_ACTIVE     = (s_q.ng == NG_RUN);
   assign MOTOR_SPEED_CMD    = s_q.motor_cmd;
   assign ENGINE_SOUND_LEVEL = s_q.engine_level;
   assign ACCEL_INHIBIT      = s_q.inhibit;
   assign ACK_STRENGTH       = s_q.cv.ack_strength;
   assign DIR_REVERSE        = s_q.cv.primary[`DCB_PRI_REVERSE];
   assign ANALOG_EN          = s_q.cv.primary[`DCB_PRI_ANALOG];
   assign TELEMETRY_EN       = s_q.cv.primary[`DCB_PRI_TELEMETRY];
   assign SPEED_TABLE_28     = s_q.cv.primary[`DCB_PRI_TABLE28];
   assign LONG_ADDR_EN       = s_q.cv.primary[`DCB_PRI_LONG_ADDR];
   // address rebuilt from the high byte offset by its base, as the station splits it
   assign LONG_ADDRESS       = {high_part[5:0], s_q.cv.long_low};
   assign LOAD_CTRL_EN       = s_q.cv.secondary[`DCB_SEC_LOAD_CTRL];
   assign CONST_BRAKE_EN     = s_q.cv.secondary[`DCB_SEC_CONST_BRAKE];
   assign RAMP_PROLONG       = s_q.cv.secondary[`DCB_SEC_PROLONG];
   assign FUNC_SAVE_EN       = s_q.cv.secondary[`DCB_SEC_FUNC_SAVE];
   assign FUNC_SAVED         = s_q.saved_func;
   assign CONSIST_ACTIVE     = s_q.cv.secondary[`DCB_SEC_CONSIST_BTN]
                               ? FUNC_BUTTONS[CONSIST_BUTTON] : CONSIST_CONFIGURED;
   assign PUFF_START         = s_q.puff;
   assign ENERGY_PACK_EN     = s_q.cv.secondary[`DCB_SEC_ENERGY_PACK];
   assign SUSI_EN            = s_q.cv.secondary[`DCB_SEC_SUSI];
   assign MAIN_SOUND_ON      = FUNC_BUTTONS[`DCB_BTN_MAIN_SOUND];
   assign SHUNT_MODE         = FUNC_BUTTONS[`DCB_BTN_SHUNT];
   assign AUX_OUT            = FUNC_BUTTONS[`DCB_BTN_AUX_FIRST +: 7];
endmodule
`default_nettype wire

// *** rtl/dcb_defs.svh ***
// configuration-variable numbers, bit positions, reset values and timing for the cv bank
`ifndef DCB_DEFS_SVH
`define DCB_DEFS_SVH

// ==================================================================
// variable numbers as written by the command station
`define DCB_CV_COMMAND        10'h008
`define DCB_CV_LONG_HIGH      10'h011
`define DCB_CV_LONG_LOW       10'h012
`define DCB_CV_PRIMARY        10'h01D
`define DCB_CV_SECONDARY      10'h031
`define DCB_CV_ACK_STRENGTH   10'h039
`define DCB_CV_NEUTRAL_SEL    10'h0AC
`define DCB_CV_MUTE_SEL       10'h0AF
`define DCB_CV_IDLE_FADE      10'h0CE
`define DCB_CV_ACCEL_SEL      10'h0D6

// ==================================================================
// command variable values
`define DCB_CMD_RESTORE       8'h00
`define DCB_CMD_RELOAD        8'h08
`define DCB_CMD_SAVE          8'h10

// ==================================================================
// primary configuration bits
`define DCB_PRI_REVERSE       0
`define DCB_PRI_ANALOG        2
`define DCB_PRI_TELEMETRY     3
`define DCB_PRI_TABLE28       4
`define DCB_PRI_LONG_ADDR     5

// ==================================================================
// secondary configuration bits
`define DCB_SEC_LOAD_CTRL     0
`define DCB_SEC_CONST_BRAKE   1
`define DCB_SEC_PROLONG       2
`define DCB_SEC_FUNC_SAVE     3
`define DCB_SEC_CONSIST_BTN   4
`define DCB_SEC_EXT_TRIGGER   5
`define DCB_SEC_ENERGY_PACK   6
`define DCB_SEC_SUSI          7

// ==================================================================
// reset (factory) values and the long-address high-byte base
`define DCB_RST_PRIMARY       8'h08
`define DCB_RST_SECONDARY     8'h07
`define DCB_RST_NEUTRAL_SEL   8'h14
`define DCB_RST_MUTE_SEL      8'h1C
`define DCB_RST_IDLE_FADE     8'hFF
`define DCB_RST_ACCEL_SEL     8'h00
`define DCB_RST_ACK_STRENGTH  8'h80
`define DCB_RST_LONG_HIGH     8'hC0
`define DCB_RST_LONG_LOW      8'h00
`define DCB_LONG_HIGH_BASE    8'hC0

// ==================================================================
// default button numbers and timing
`define DCB_BTN_MAIN_SOUND    1
`define DCB_BTN_SHUNT         6
`define DCB_BTN_AUX_FIRST     21
`define DCB_BTN_SAVE_FIRST    13
`define DCB_BTN_MAX           29
`define DCB_CLK_PERIOD_NS     10
`define DCB_RAMP_STEP_NS      100000

`endif

// *** rtl/dcb_gain_ramp.sv ***
// gain that walks toward its target in fixed steps on each enable pulse
`timescale 1ns/1ps
`default_nettype none

module dcb_gain_ramp #(
   parameter int WIDTH = 8,
   parameter int STEP  = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             step_en,
   input  wire logic [WIDTH-1:0] target,
   output logic      [WIDTH-1:0] gain
);
   typedef struct packed {
      logic [WIDTH-1:0] gain;
   } dcb_ramp_st_type;

   localparam logic [WIDTH:0] STEP_W = (WIDTH+1)'(STEP);

   dcb_ramp_st_type st_q;
   dcb_ramp_st_type st_d;
   logic [WIDTH:0]  up;
   logic [WIDTH:0]  down;

   // wide sums so a step never wraps past the target
   always_comb begin
      st_d = st_q;
      up   = {1'b0, st_q.gain} + STEP_W;
      down = {1'b0, st_q.gain} - STEP_W;
      if (step_en) begin
         if (st_q.gain < target) begin
            st_d.gain = (up[WIDTH] || (up[WIDTH-1:0] > target)) ? target : up[WIDTH-1:0];
         end else if (st_q.gain > target) begin
            st_d.gain = (down[WIDTH] || (down[WIDTH-1:0] < target)) ? target
                                                                   : down[WIDTH-1:0];
         end
      end
      if (!rst_n) begin
         st_d.gain = '1;
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign gain = st_q.gain;
endmodule
`default_nettype wire

// *** rtl/dcb_pkg.sv ***
// types shared by the cv bank modules
package dcb_pkg;

   // ==================================================================
   // stored variable set, also used as the saved image
   typedef struct packed {
      logic [7:0] primary;
      logic [7:0] secondary;
      logic [7:0] neutral_sel;
      logic [7:0] mute_sel;
      logic [7:0] idle_fade;
      logic [7:0] accel_sel;
      logic [7:0] ack_strength;
      logic [7:0] long_high;
      logic [7:0] long_low;
   } dcb_cv_type;

   typedef enum logic [0:0] {NG_OFF, NG_RUN} dcb_ng_type;

   typedef enum logic [1:0] {PEND_NONE, PEND_RESTORE, PEND_RELOAD} dcb_pend_type;

   typedef struct packed {
      dcb_cv_type   cv;
      dcb_cv_type   shadow;
      dcb_pend_type pend;
      logic [15:0]  saved_func;
      dcb_ng_type   ng;
      logic [15:0]  tick_cnt;
      logic         trig_q;
      logic         puff;
      logic         inhibit;
      logic [7:0]   motor_cmd;
      logic [7:0]   engine_level;
      logic [7:0]   rdata;
      logic         rvalid;
   } dcb_state_type;

endpackage

// *** sim/dcb_cv_bank_bench.sv ***
// self-checking bench for the cv bank
`timescale 1ns/1ps
`default_nettype none

module dcb_cv_bank_bench;
   localparam logic [7:0] ID = 8'hA5; // arbitrary maker value
   logic        REF_CLK, RST_N, NV_INIT_N, CV_WR_EN, CV_RD_EN, CV_RD_VALID, ACCELERATING;
   logic        DECELERATING, STOPPED, EXT_TRIGGER, PUFF_TIMER_TICK, CONSIST_CONFIGURED;
   logic        NEUTRAL_ACTIVE, ACCEL_INHIBIT, DIR_REVERSE, ANALOG_EN, TELEMETRY_EN;
   logic        SPEED_TABLE_28, LONG_ADDR_EN, LOAD_CTRL_EN, CONST_BRAKE_EN, RAMP_PROLONG;
   logic        FUNC_SAVE_EN, CONSIST_ACTIVE, PUFF_START, ENERGY_PACK_EN, SUSI_EN;
   logic        MAIN_SOUND_ON, SHUNT_MODE;
   logic [9:0]  CV_NUM;
   logic [7:0]  CV_WDATA, CV_RDATA, THROTTLE, FADE_GAIN, MASTER_GAIN, MOTOR_SPEED_CMD;
   logic [7:0]  ENGINE_SOUND_LEVEL, ACK_STRENGTH, rv;
   logic [31:0] FUNC_BUTTONS;
   logic [3:0]  TRACK_OUTPUT_FLAG;
   logic [13:0] LONG_ADDRESS;
   logic [15:0] FUNC_SAVED;
   logic [6:0]  AUX_OUT;
   logic [9:0]  rn [9] = '{10'h01D, 10'h031, 10'h0AC, 10'h0AF, 10'h0CE, 10'h0D6, 10'h039,
                           10'h011, 10'h012};
   logic [7:0]  rd0 [9] = '{8'h08, 8'h07, 8'h14, 8'h1C, 8'hFF, 8'h00, 8'h80, 8'hC0, 8'h00};
   int          err_total = 0;
   int          num_checks = 0;

   dcb_cv_bank #(.RAMP_STEP_CYCLES(4), .MAKER_ID(ID)) dut_u (
      .REF_CLK, .RST_N, .NV_INIT_N, .CV_WR_EN, .CV_RD_EN, .CV_NUM, .CV_WDATA, .CV_RDATA,
      .CV_RD_VALID, .FUNC_BUTTONS, .THROTTLE, .ACCELERATING, .DECELERATING, .STOPPED,
      .TRACK_OUTPUT_FLAG, .EXT_TRIGGER, .PUFF_TIMER_TICK, .CONSIST_CONFIGURED, .FADE_GAIN,
      .MASTER_GAIN, .NEUTRAL_ACTIVE, .MOTOR_SPEED_CMD, .ENGINE_SOUND_LEVEL, .ACCEL_INHIBIT,
      .ACK_STRENGTH, .DIR_REVERSE, .ANALOG_EN, .TELEMETRY_EN, .SPEED_TABLE_28, .LONG_ADDR_EN,
      .LONG_ADDRESS, .LOAD_CTRL_EN, .CONST_BRAKE_EN, .RAMP_PROLONG, .FUNC_SAVE_EN, .FUNC_SAVED,
      .CONSIST_ACTIVE, .PUFF_START, .ENERGY_PACK_EN, .SUSI_EN, .MAIN_SOUND_ON, .SHUNT_MODE,
      .AUX_OUT);
   dcb_station st_u (.REF_CLK, .CV_WR_EN, .CV_RD_EN, .CV_NUM, .CV_WDATA, .CV_RDATA, .CV_RD_VALID);

   initial begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end

   // ====================
   // helpers
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input logic [9:0] n, input logic [7:0] exp);
      st_u.rd(n, rv);
      chk("cv read", {8'h00, rv}, {8'h00, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge REF_CLK);
   endtask
   task automatic restart();
      @(negedge REF_CLK);
      RST_N = 1'b0;
      @(negedge REF_CLK);
      RST_N = 1'b1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // full mute ramps take about 1020 cycles each, the fade ramps about 508, the whole run under 5000
   initial begin
      repeat (20000) @(posedge REF_CLK);
      err_total++;
      report_and_stop();
   end

   // ====================
   // scenarios
   initial begin
      {RST_N, NV_INIT_N, ACCELERATING, DECELERATING, STOPPED} = 5'h00;
      {EXT_TRIGGER, PUFF_TIMER_TICK, CONSIST_CONFIGURED} = 3'h0;
      FUNC_BUTTONS = 32'h0000_0000;
      THROTTLE = 8'h00;
      TRACK_OUTPUT_FLAG = 4'h0;
      cyc(4);
      {RST_N, NV_INIT_N} = 2'h3;
      foreach (rn[i]) rchk(rn[i], rd0[i]);
      rchk(10'h008, ID);
      st_u.wr(10'h3FF, 8'h5C);
      rchk(10'h3FF, 8'h00);
      st_u.long_addr(1234);
      chk("long address", {2'b00, LONG_ADDRESS}, 16'h04D2);
      chk("primary", {11'h000, LONG_ADDR_EN, SPEED_TABLE_28, TELEMETRY_EN, ANALOG_EN,
         DIR_REVERSE}, 16'h0014);
      st_u.wr(10'h01D, 8'h15);
      chk("primary", {11'h000, LONG_ADDR_EN, SPEED_TABLE_28, TELEMETRY_EN, ANALOG_EN,
         DIR_REVERSE}, 16'h000B);
      FUNC_BUTTONS = 32'h0125_60C2;
      st_u.wr(10'h031, 8'hFF);
      cyc(2);
      chk("secondary", {10'h000, SUSI_EN, ENERGY_PACK_EN, FUNC_SAVE_EN, RAMP_PROLONG,
         CONST_BRAKE_EN, LOAD_CTRL_EN}, 16'h003F);
      chk("saved buttons", FUNC_SAVED, 16'h092B);
      chk("consist", {15'h0000, CONSIST_ACTIVE}, 16'h0001);
      chk("buttons", {7'h00, MAIN_SOUND_ON, SHUNT_MODE, AUX_OUT}, 16'h0189);
      PUFF_TIMER_TICK = 1'b1;
      cyc(1);
      PUFF_TIMER_TICK = 1'b0;
      chk("puff timer", {15'h0000, PUFF_START}, 16'h0000);
      EXT_TRIGGER = 1'b1;
      cyc(1);
      chk("puff trigger", {15'h0000, PUFF_START}, 16'h0001);
      st_u.wr(10'h031, 8'h00);
      FUNC_BUTTONS = 32'h0000_0000;
      CONSIST_CONFIGURED = 1'b1;
      PUFF_TIMER_TICK = 1'b1;
      cyc(1);
      PUFF_TIMER_TICK = 1'b0;
      chk("puff timer", {15'h0000, PUFF_START}, 16'h0001);
      chk("consist", {15'h0000, CONSIST_ACTIVE}, 16'h0001);
      st_u.wr(10'h0D6, 8'hF5);
      for (int f = 0; f < 16; f++) begin
         TRACK_OUTPUT_FLAG = 4'(f);
         cyc(2);
         chk("inhibit", {15'h0000, ACCEL_INHIBIT}, {15'h0000, |(4'(f) & 4'h5)});
      end
      THROTTLE = 8'h32;
      FUNC_BUTTONS = 32'h0010_0000;
      cyc(2);
      chk("neutral", {15'h0000, NEUTRAL_ACTIVE}, 16'h0000);
      STOPPED = 1'b1;
      cyc(2);
      chk("neutral", {15'h0000, NEUTRAL_ACTIVE}, 16'h0001);
      chk("engine", {MOTOR_SPEED_CMD, ENGINE_SOUND_LEVEL}, 16'h0032);
      FUNC_BUTTONS = 32'h0000_0000;
      cyc(2);
      chk("neutral", {15'h0000, NEUTRAL_ACTIVE}, 16'h0001);
      THROTTLE = 8'h00;
      cyc(2);
      chk("neutral", {15'h0000, NEUTRAL_ACTIVE}, 16'h0000);
      st_u.wr(10'h0AC, 8'h05);
      FUNC_BUTTONS = 32'h0000_0020;
      cyc(2);
      chk("neutral", {15'h0000, NEUTRAL_ACTIVE}, 16'h0001);
      FUNC_BUTTONS = 32'h0000_0000;
      STOPPED = 1'b0;
      st_u.wr(10'h0CE, 8'h80);
      cyc(600);
      chk("fade", {8'h00, FADE_GAIN}, 16'h0080);
      ACCELERATING = 1'b1;
      cyc(600);
      chk("fade", {8'h00, FADE_GAIN}, 16'h00FF);
      ACCELERATING = 1'b0;
      st_u.wr(10'h0AF, 8'h03);
      FUNC_BUTTONS = 32'h1000_0000;
      cyc(20);
      chk("mute", {8'h00, MASTER_GAIN}, 16'h00FF);
      FUNC_BUTTONS = 32'h0000_0008;
      cyc(1100);
      chk("mute", {8'h00, MASTER_GAIN}, 16'h0000);
      FUNC_BUTTONS = 32'h0000_0000;
      cyc(1100);
      chk("mute", {8'h00, MASTER_GAIN}, 16'h00FF);
      st_u.pace = 3;
      st_u.wr(10'h039, 8'h33);
      st_u.wr(10'h008, 8'h10);
      st_u.wr(10'h039, 8'h44);
      st_u.wr(10'h008, 8'h08);
      rchk(10'h039, 8'h44);
      restart();
      rchk(10'h039, 8'h33);
      st_u.wr(10'h008, 8'h00);
      rchk(10'h039, 8'h33);
      restart();
      rchk(10'h039, 8'h80);
      chk("ack", {8'h00, ACK_STRENGTH}, 16'h0080);
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** sim/dcb_cv_bank_properties.sv ***
// assertion checker for the cv bank ports
`timescale 1ns/1ps
`default_nettype none
`include "dcb_defs.svh"

module dcb_cv_bank_properties #(
   parameter int RAMP_STEP = 1
) (
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        NV_INIT_N,
   input wire logic        CV_WR_EN,
   input wire logic [9:0]  CV_NUM,
   input wire logic [7:0]  CV_WDATA,
   input wire logic [31:0] FUNC_BUTTONS,
   input wire logic [7:0]  THROTTLE,
   input wire logic        DECELERATING,
   input wire logic        STOPPED,
   input wire logic [7:0]  FADE_GAIN,
   input wire logic [7:0]  MASTER_GAIN,
   input wire logic        NEUTRAL_ACTIVE,
   input wire logic [7:0]  MOTOR_SPEED_CMD,
   input wire logic [7:0]  ACK_STRENGTH,
   input wire logic        DIR_REVERSE,
   input wire logic        ANALOG_EN,
   input wire logic        TELEMETRY_EN,
   input wire logic        SPEED_TABLE_28,
   input wire logic        LONG_ADDR_EN,
   input wire logic        LOAD_CTRL_EN,
   input wire logic        CONST_BRAKE_EN,
   input wire logic        RAMP_PROLONG,
   input wire logic        FUNC_SAVE_EN,
   input wire logic [15:0] FUNC_SAVED,
   input wire logic        ENERGY_PACK_EN,
   input wire logic        SUSI_EN
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   // ====================
   // variable writes
   sequence s_wr(n);
      CV_WR_EN && CV_NUM == n;
   endsequence
   property p_primary;
      s_wr(`DCB_CV_PRIMARY) |=> {LONG_ADDR_EN, SPEED_TABLE_28, TELEMETRY_EN, ANALOG_EN,
         DIR_REVERSE} == {$past(CV_WDATA[5:2]), $past(CV_WDATA[0])};
   endproperty
   a_primary: assert property (p_primary) else $error("primary bits wrong");
   property p_secondary;
      s_wr(`DCB_CV_SECONDARY) |=> {SUSI_EN, ENERGY_PACK_EN, FUNC_SAVE_EN, RAMP_PROLONG,
         CONST_BRAKE_EN, LOAD_CTRL_EN} == {$past(CV_WDATA[7:6]), $past(CV_WDATA[3:0])};
   endproperty
   a_secondary: assert property (p_secondary) else $error("secondary bits wrong");
   property p_ack;
      s_wr(`DCB_CV_ACK_STRENGTH) |=> ACK_STRENGTH == $past(CV_WDATA);
   endproperty
   a_ack: assert property (p_ack) else $error("ack strength wrong");
   // nv clear overrides the snapshot, so it is left out
   property p_save;
      FUNC_SAVE_EN && NV_INIT_N |=> FUNC_SAVED == $past(FUNC_BUTTONS[28:13]);
   endproperty
   a_save: assert property (p_save) else $error("button snapshot wrong");

   // ====================
   // neutral gear
   property p_ng_enter;
      $rose(NEUTRAL_ACTIVE) |-> $past(STOPPED) || $past(DECELERATING);
   endproperty
   a_ng_enter: assert property (p_ng_enter) else $error("neutral entered while moving");
   property p_ng_leave;
      $past(RST_N) && $fell(NEUTRAL_ACTIVE) |-> $past(THROTTLE) == 8'h00;
   endproperty
   a_ng_leave: assert property (p_ng_leave) else $error("neutral left at nonzero throttle");
   property p_ng_hold;
      NEUTRAL_ACTIVE |-> MOTOR_SPEED_CMD == 8'h00;
   endproperty
   a_ng_hold: assert property (p_ng_hold) else $error("loco moves in neutral");

   // ====================
   // gain ramps move one step at a time; the reset jump is excluded
   property p_fade_step;
      $past(RST_N) && $changed(FADE_GAIN) |-> FADE_GAIN == $past(FADE_GAIN) + 8'(RAMP_STEP)
         || FADE_GAIN == $past(FADE_GAIN) - 8'(RAMP_STEP);
   endproperty
   a_fade_step: assert property (p_fade_step) else $error("fade gain jumped");
   property p_mute_step;
      $past(RST_N) && $changed(MASTER_GAIN) |-> MASTER_GAIN == $past(MASTER_GAIN) + 8'(RAMP_STEP)
         || MASTER_GAIN == $past(MASTER_GAIN) - 8'(RAMP_STEP);
   endproperty
   a_mute_step: assert property (p_mute_step) else $error("master gain jumped");
endmodule

bind dcb_cv_bank dcb_cv_bank_properties #(.RAMP_STEP(RAMP_STEP)) chk_u (
   .REF_CLK, .RST_N, .NV_INIT_N, .CV_WR_EN, .CV_NUM, .CV_WDATA, .FUNC_BUTTONS, .THROTTLE,
   .DECELERATING, .STOPPED, .FADE_GAIN, .MASTER_GAIN, .NEUTRAL_ACTIVE, .MOTOR_SPEED_CMD,
   .ACK_STRENGTH, .DIR_REVERSE, .ANALOG_EN, .TELEMETRY_EN, .SPEED_TABLE_28, .LONG_ADDR_EN,
   .LOAD_CTRL_EN, .CONST_BRAKE_EN, .RAMP_PROLONG, .FUNC_SAVE_EN, .FUNC_SAVED, .ENERGY_PACK_EN,
   .SUSI_EN);
`default_nettype wire

// *** sim/dcb_station.sv ***
// command station model that writes and reads configuration variables
`timescale 1ns/1ps
`default_nettype none

module dcb_station (
   input  wire logic       REF_CLK,
   output logic            CV_WR_EN,
   output logic            CV_RD_EN,
   output logic      [9:0] CV_NUM,
   output logic      [7:0] CV_WDATA,
   input  wire logic [7:0] CV_RDATA,
   input  wire logic       CV_RD_VALID
);
   int pace = 0;

   initial begin
      CV_WR_EN = 1'b0;
      CV_RD_EN = 1'b0;
      CV_NUM   = 10'h000;
      CV_WDATA = 8'h00;
   end

   // released lines show the inverse, so a stale number can never pass as valid
   task automatic idle();
      CV_WR_EN = 1'b0;
      CV_RD_EN = 1'b0;
      CV_NUM   = ~CV_NUM;
      CV_WDATA = ~CV_WDATA;
   endtask

   task automatic wr(input logic [9:0] n, input logic [7:0] d);
      @(negedge REF_CLK);
      CV_NUM   = n;
      CV_WDATA = d;
      CV_WR_EN = 1'b1;
      @(negedge REF_CLK);
      idle();
      repeat (pace) @(negedge REF_CLK);
   endtask

   task automatic rd(input logic [9:0] n, output logic [7:0] d);
      @(negedge REF_CLK);
      CV_NUM   = n;
      CV_RD_EN = 1'b1;
      @(negedge REF_CLK);
      idle();
      // the answer stands exactly one cycle after the strobe; a late one reads unknown
      d = (CV_RD_VALID === 1'b1) ? CV_RDATA : 8'hXX;
      repeat (pace) @(negedge REF_CLK);
   endtask

   task automatic long_addr(input int a);
      wr(10'h011, 8'(a / 256 + 192));
      wr(10'h012, 8'(a % 256));
      wr(10'h01D, 8'h28);
   endtask
endmodule
`default_nettype wire
